// File: src/rsc_pkg.sv
// constants, field positions and states of the reset source controller
// assumes a 32-bit APB slave and byte addresses below 0x20
package rsc_pkg;
    localparam int           ADDR_W       = 8;
    localparam logic [7:0]   OFF_MODE0    = 8'h00;
    localparam logic [7:0]   OFF_MODE1    = 8'h04;
    localparam logic [7:0]   OFF_CAUSE    = 8'h08;
    localparam logic [7:0]   OFF_MON      = 8'h0C;
    localparam logic [7:0]   OFF_MONSEL   = 8'h10;
    localparam logic [7:0]   OFF_OPT      = 8'h14;
    // mode registers
    localparam int           M0_SOFT      = 3;
    localparam int           M1_CLK_FAST  = 0;
    localparam int           M1_WDT_SEL   = 2;
    // cause register
    localparam int           C_COLD_WARM  = 0;
    localparam int           C_PIN        = 1;
    localparam int           C_SOFT       = 2;
    localparam int           C_WDT        = 3;
    // one byte per monitor inside the monitor register
    localparam int           MN_INT_EN    = 0;
    localparam int           MN_FILT_OFF  = 1;
    localparam int           MN_DET       = 2;
    localparam int           MN_STATE     = 3;
    localparam int           MN_DIV_LO    = 4;
    localparam int           MN_EDGE_FALL = 7;
    localparam logic [7:0]   MON_RST      = 8'h8A;
    // monitor select register
    localparam int           MS_LVL1_LO   = 0;
    localparam int           MS_IRQSEL_LO = 4;
    localparam int           MS_TYPE_EN   = 6;
    localparam int           MS_BOTH_LO   = 7;
    localparam logic [8:0]   MONSEL_RST   = 9'h000;
    // option byte fields: main in [7:0], second in [15:8]
    localparam int           OP_LVL0_LO   = 4;
    localparam int           OP_MON0_OPT  = 6;
    localparam int           OP_PER_LO    = 8;
    localparam int           OP_WIN_LO    = 10;
    localparam int           SEQ_CYCLES   = 32;
    typedef enum logic [1:0] {RSC_RUN, RSC_HOLD, RSC_COUNT} rsc_state_e;
endpackage

// File: src/rsc_top.sv
// reset source controller: gathers pin, power-on/monitor 0, watchdog and
// software resets, sequences the internal reset, records its cause, and
// hosts the supply monitors 1 and 2 with filters and interrupt requests.
// assumes CLOCK is the slow on-chip oscillator and comparators are async.
//
// Contract
// - pin low holds system in reset; release starts fetch from reset vector
// - after any reset the slow oscillator, undivided, is the processor clock
// - reset never clears RAM; reset during RAM write marks RAM undefined
// - after supply reaches level 0, count 32 slow cycles then release
// - power-on and monitor 0 reset act only when start option bit is 0
// - supply at or below level 0 resets the system
// - level 0 select and start option come only from the option byte
// - watchdog underflow resets when watchdog reset select is 1
// - watchdog period and window come from the second option byte
// - writing 1 to the software reset bit resets the system
// - cold/warm flag cleared by power-on and monitor 0, set by write 1
// - pin, software and watchdog reset flags set on their reset
// - level 0 has four levels, level 1 sixteen, level 2 fixed
// - monitors 1 and 2 detect chosen edges, request NMI or maskable IRQ
// - read-only above/below flags exist for levels 1 and 2 only
// - monitors 1 and 2 have switchable filter, slow clock over 1,2,4,8
// - the software reset bit always reads 0
`timescale 1ns/100ps
module rsc_top
#(
    parameter int SEQ_LEN = rsc_pkg::SEQ_CYCLES
)
(
    // clock and reset
    input  wire  logic                        CLOCK,
    input  wire  logic                        RSTN,
    input  wire  logic                        CLK_EN,
    // apb slave
    input  wire  logic                        PSEL,
    input  wire  logic                        PENABLE,
    input  wire  logic                        PWRITE,
    input  wire  logic [rsc_pkg::ADDR_W-1:0]  PADDR,
    input  wire  logic [31:0]                 PWDATA,
    output logic       [31:0]                 PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR,
    // pins, comparators and option bytes, all asynchronous
    input  wire  logic                        RESET_PIN_N,
    input  wire  logic                        CMP0_ABOVE,
    input  wire  logic                        CMP1_ABOVE,
    input  wire  logic                        CMP2_ABOVE,
    input  wire  logic [7:0]                  OPTION_MAIN,
    input  wire  logic [7:0]                  OPTION_SECOND,
    // on-chip neighbours
    input  wire  logic                        WDT_UNDERFLOW,
    input  wire  logic                        RAM_WR_BUSY,
    // results
    output logic                              SYS_RESET_N,
    output logic                              FETCH_VECTOR,
    output logic                              CPU_CLK_SLOW,
    output logic                              RAM_UNDEF,
    output logic                              NMI_REQ,
    output logic                              IRQ_REQ,
    output logic       [1:0]                  LEVEL0_SEL,
    output logic       [3:0]                  LEVEL1_SEL,
    output logic       [1:0]                  WDT_PERIOD_SEL,
    output logic       [1:0]                  WDT_WINDOW_SEL
);
    import rsc_pkg::*;

    localparam int CNT_W = $clog2(SEQ_LEN);

    // a single-state count could never tell the release edge apart
    if (SEQ_LEN < 2 || SEQ_LEN > 4096)
    begin : g_bad_len
        $error("SEQ_LEN out of range");
    end

    logic [19:0]      s1_ff;
    logic [19:0]      s2_ff;
    rsc_state_e       state_ff;
    rsc_state_e       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [3:0]       cause_ff;
    logic             wdt_sel_ff;
    logic [8:0]       monsel_ff;
    logic [7:0]       mon_ff [2];
    logic [1:0]       lvl_w;
    logic [1:0]       irq_vec;
    logic [1:0]       nmi_vec;
    logic [2:0]       pre_ff;
    logic [31:0]      nxt_prdata;
    logic             hit;

    // pins, comparators and option bytes pass two flops before use
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            // idle levels: pin released, supply above every threshold
            s1_ff <= 20'h0000F;
            s2_ff <= 20'h0000F;
        end
        else if (CLK_EN)
        begin
            s1_ff <= {OPTION_SECOND, OPTION_MAIN, CMP2_ABOVE, CMP1_ABOVE,
                      CMP0_ABOVE, RESET_PIN_N};
            s2_ff <= s1_ff;
        end
    end

    wire         pin_s   = s2_ff[0];
    wire         cmp0_s  = s2_ff[1];
    wire  [1:0]  cmp_s   = s2_ff[3:2];
    wire  [15:0] opt_s   = s2_ff[19:4];

    wire in_run   = (state_ff == RSC_RUN);
    wire wr_en    = PSEL && PENABLE && PREADY && PWRITE && in_run;
    wire pin_rst  = !pin_s;
    wire mon0_low = !opt_s[OP_MON0_OPT] && !cmp0_s;
    wire soft_req = wr_en && PADDR == OFF_MODE0 && PWDATA[M0_SOFT];
    wire wdt_req  = in_run && wdt_sel_ff && WDT_UNDERFLOW;
    wire level_src = pin_rst || mon0_low;

    // level sources hold reset; the count only starts once all are gone
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            RSC_RUN:
                if (level_src || soft_req || wdt_req)
                    nxt_state = RSC_HOLD;
            RSC_HOLD:
                if (!level_src)
                    nxt_state = RSC_COUNT;
            RSC_COUNT:
                if (level_src)
                    nxt_state = RSC_HOLD;
                else if (cnt_ff == CNT_W'(SEQ_LEN - 1))
                    nxt_state = RSC_RUN;
            default:
                nxt_state = RSC_HOLD;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            state_ff <= RSC_HOLD;
            cnt_ff   <= '0;
        end
        else if (CLK_EN)
        begin
            state_ff <= nxt_state;
            cnt_ff   <= (state_ff == RSC_COUNT && nxt_state == RSC_COUNT)
                        ? cnt_ff + 1'b1 : '0;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            SYS_RESET_N  <= 1'b0;
            FETCH_VECTOR <= 1'b0;
            RAM_UNDEF    <= 1'b0;
        end
        else if (CLK_EN)
        begin
            SYS_RESET_N  <= (nxt_state == RSC_RUN);
            FETCH_VECTOR <= (state_ff == RSC_COUNT) && (nxt_state == RSC_RUN);
            // ram is left untouched; only flag a write cut short
            if (in_run && nxt_state != RSC_RUN && RAM_WR_BUSY)
                RAM_UNDEF <= 1'b1;
        end
    end

    // cause flags and cold/warm survive every reset except the block's own and monitor 0
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
            cause_ff <= 4'h0;
        else if (CLK_EN)
        begin
            if (mon0_low)
                cause_ff <= 4'h0;
            else
            begin
                if (wr_en && PADDR == OFF_CAUSE && PWDATA[C_COLD_WARM])
                    cause_ff[C_COLD_WARM] <= 1'b1;
                if (pin_rst)
                    cause_ff[C_PIN] <= 1'b1;
                if (soft_req)
                    cause_ff[C_SOFT] <= 1'b1;
                if (wdt_req)
                    cause_ff[C_WDT] <= 1'b1;
            end
        end
    end

    // control registers fall back to defaults while the system is in reset
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN || (CLK_EN && !in_run))
        begin
            CPU_CLK_SLOW <= 1'b1;
            wdt_sel_ff   <= 1'b0;
            monsel_ff    <= MONSEL_RST;
        end
        else if (CLK_EN)
        begin
            if (wr_en && PADDR == OFF_MODE1)
            begin
                CPU_CLK_SLOW <= !PWDATA[M1_CLK_FAST];
                wdt_sel_ff   <= PWDATA[M1_WDT_SEL];
            end
            if (wr_en && PADDR == OFF_MONSEL)
                monsel_ff <= PWDATA[8:0];
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
            pre_ff <= 3'h0;
        else if (CLK_EN)
            pre_ff <= pre_ff + 3'h1;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_mon
            logic       smp_ff;
            logic       flt_ff;
            logic       prv_ff;
            logic [1:0] dv;
            logic [2:0] msk;
            logic       tick;
            logic       lvl;
            logic       evt;
            logic       mask_t;
            assign dv   = mon_ff[g][MN_DIV_LO +: 2];
            assign msk  = {dv == 2'h3, dv[1], dv != 2'h0};
            assign tick = (pre_ff & msk) == 3'h0;
            assign lvl  = mon_ff[g][MN_FILT_OFF] ? cmp_s[g] : flt_ff;
            assign evt  = monsel_ff[MS_BOTH_LO + g] ? (lvl != prv_ff)
                        : (mon_ff[g][MN_EDGE_FALL] ? (prv_ff && !lvl)
                                                    : (!prv_ff && lvl));
            assign mask_t      = monsel_ff[MS_TYPE_EN] && monsel_ff[MS_IRQSEL_LO + g];
            assign lvl_w[g]    = lvl;
            assign irq_vec[g]  = mon_ff[g][MN_DET] && mon_ff[g][MN_INT_EN] && mask_t;
            assign nmi_vec[g]  = mon_ff[g][MN_DET] && mon_ff[g][MN_INT_EN] && !mask_t;

            // two agreeing samples, spaced by the divided clock, move the level
            always_ff @(posedge CLOCK)
            begin
                if (!RSTN)
                begin
                    smp_ff <= 1'b1;
                    flt_ff <= 1'b1;
                    prv_ff <= 1'b1;
                end
                else if (CLK_EN)
                begin
                    if (tick)
                    begin
                        smp_ff <= cmp_s[g];
                        if (smp_ff == cmp_s[g])
                            flt_ff <= smp_ff;
                    end
                    prv_ff <= lvl;
                end
            end

            always_ff @(posedge CLOCK)
            begin
                if (!RSTN || (CLK_EN && !in_run))
                    mon_ff[g] <= MON_RST;
                else if (CLK_EN)
                begin
                    if (wr_en && PADDR == OFF_MON)
                    begin
                        mon_ff[g] <= PWDATA[8*g +: 8];
                        // detect flag: writing 0 clears, writing 1 keeps
                        mon_ff[g][MN_DET] <= mon_ff[g][MN_DET] && PWDATA[8*g+MN_DET];
                    end
                    // an edge in the clearing cycle still sets the flag
                    if (evt && mon_ff[g][MN_INT_EN])
                        mon_ff[g][MN_DET] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            NMI_REQ        <= 1'b0;
            IRQ_REQ        <= 1'b0;
            LEVEL0_SEL     <= 2'h0;
            LEVEL1_SEL     <= 4'h0;
            WDT_PERIOD_SEL <= 2'h0;
            WDT_WINDOW_SEL <= 2'h0;
        end
        else if (CLK_EN)
        begin
            NMI_REQ        <= |nmi_vec;
            IRQ_REQ        <= |irq_vec;
            LEVEL0_SEL     <= opt_s[OP_LVL0_LO +: 2];
            LEVEL1_SEL     <= monsel_ff[MS_LVL1_LO +: 4];
            WDT_PERIOD_SEL <= opt_s[OP_PER_LO +: 2];
            WDT_WINDOW_SEL <= opt_s[OP_WIN_LO +: 2];
        end
    end

    always_comb
    begin
        nxt_prdata = 32'h00000000;
        hit        = 1'b1;
        case (PADDR)
            OFF_MODE0:  nxt_prdata = 32'h00000000;
            OFF_MODE1:  nxt_prdata = {29'h0, wdt_sel_ff, 1'b0, !CPU_CLK_SLOW};
            OFF_CAUSE:  nxt_prdata = {28'h0, cause_ff};
            OFF_MON:
            begin
                nxt_prdata[15:0] = {mon_ff[1], mon_ff[0]};
                nxt_prdata[MN_STATE]     = lvl_w[0];
                nxt_prdata[8 + MN_STATE] = lvl_w[1];
            end
            OFF_MONSEL: nxt_prdata = {23'h0, monsel_ff};
            OFF_OPT:    nxt_prdata = {16'h0, opt_s};
            default:    hit = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end
        else if (CLK_EN)
        begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !hit;
            if (PSEL && PENABLE && !PREADY && !PWRITE)
                PRDATA <= nxt_prdata;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN || !CLK_EN);

    a_pin_holds:   assert property (pin_rst |=> !SYS_RESET_N)
        else $error("pin low did not hold reset");
    a_seq_release: assert property (state_ff == RSC_COUNT && cnt_ff == CNT_W'(SEQ_LEN-1)
        && !level_src |=> SYS_RESET_N && FETCH_VECTOR)
        else $error("count end did not release reset");
    a_fetch_rise:  assert property ($rose(SYS_RESET_N) |-> FETCH_VECTOR && CPU_CLK_SLOW)
        else $error("release without fetch on slow clock");
    a_mon0_gate:   assert property (in_run && opt_s[OP_MON0_OPT] && pin_s && !soft_req
        && !wdt_req |=> in_run)
        else $error("monitor 0 acted while disabled");
    a_mon0_clear:  assert property (mon0_low |=> !cause_ff[C_COLD_WARM] && !SYS_RESET_N)
        else $error("monitor 0 reset kept warm flag");
    a_soft_seq:    assert property (soft_req && !mon0_low
        |=> !SYS_RESET_N && cause_ff[C_SOFT])
        else $error("software reset missed");
    a_wdt_seq:     assert property (wdt_req && !mon0_low
        |=> !SYS_RESET_N && cause_ff[C_WDT])
        else $error("watchdog reset missed");
    a_soft_read0:  assert property (PREADY && !PWRITE && PADDR == OFF_MODE0
        |-> !PRDATA[M0_SOFT])
        else $error("software reset bit read as 1");
    a_hold_all:    assert property (state_ff == RSC_HOLD && level_src |=> !SYS_RESET_N)
        else $error("released with a source active");

    c_soft:  cover property (soft_req ##[1:40] $rose(SYS_RESET_N));
    c_pin:   cover property (pin_rst ##1 !pin_rst ##[1:40] FETCH_VECTOR);
    c_irq:   cover property ($rose(IRQ_REQ) || $rose(NMI_REQ));
endmodule // rsc_top

// File: bench/rsc_partner.sv
// partner model: external reset circuit and the supply rail comparators
// assumes the bench calls each task from at most one process at a time
`timescale 1ns/100ps
module rsc_partner
#(
    parameter int SETTLE = 16
)
(
    // pacing clock
    input  wire logic clk,
    // reset pin and supply comparators
    output logic      reset_pin_n,
    output logic      cmp0_above,
    output logic      cmp1_above,
    output logic      cmp2_above
);
    // 10 us at 40 ns per cycle
    localparam int HOLD_CYC = 250;
    initial
    begin
        reset_pin_n = 1'b0;
        cmp0_above  = 1'b0;
        cmp1_above  = 1'b1;
        cmp2_above  = 1'b1;
        repeat (4) @(posedge clk);
        cmp0_above <= 1'b1;
        // pin stays low for settling plus the hold time
        repeat (SETTLE + HOLD_CYC) @(posedge clk);
        reset_pin_n <= 1'b1;
    end
    task automatic pin_pulse(input int n);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        // never shorter than the documented minimum low time
        repeat ((n < HOLD_CYC) ? HOLD_CYC : n) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask
    task automatic dip(input int n);
        @(posedge clk);
        cmp0_above <= 1'b0;
        repeat (n) @(posedge clk);
        cmp0_above <= 1'b1;
    endtask
    task automatic rail(input logic a1, input logic a2);
        cmp1_above <= a1;
        cmp2_above <= a2;
    endtask
endmodule // rsc_partner

// File: bench/test_reset_source_controller.sv
// testbench: apb master, reset sources and a cause-flag model
// assumes the one-wait-state apb slave and the default reset count
`timescale 1ns/100ps
module test_reset_source_controller;
    import rsc_pkg::*;
    localparam int SEQ = SEQ_CYCLES;
    logic        clk_en = 1'b1;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, pin_n, c0, c1, c2;
    logic [7:0]  opt_m, opt_s;
    logic        wdt_uf = 1'b0;
    logic        ram_busy = 1'b0;
    logic        sys_n, fetch, clk_slow, ram_undef, nmi, irq;
    logic [1:0]  lvl0, per, win;
    logic [3:0]  lvl1, lvl;
    logic [31:0] rd;
    logic        er;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cause_m = 0;
    int          n;
    int unsigned seed = 8764;

    always #20 clock = ~clock;

    rsc_partner u_rsc_partner (.clk(clock), .reset_pin_n(pin_n), .cmp0_above(c0),
        .cmp1_above(c1), .cmp2_above(c2));
    rsc_top #(.SEQ_LEN(SEQ)) u_rsc_top (.CLOCK(clock), .RSTN(rstn), .CLK_EN(clk_en),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESET_PIN_N(pin_n), .CMP0_ABOVE(c0), .CMP1_ABOVE(c1), .CMP2_ABOVE(c2),
        .OPTION_MAIN(opt_m), .OPTION_SECOND(opt_s), .WDT_UNDERFLOW(wdt_uf),
        .RAM_WR_BUSY(ram_busy), .SYS_RESET_N(sys_n), .FETCH_VECTOR(fetch),
        .CPU_CLK_SLOW(clk_slow), .RAM_UNDEF(ram_undef), .NMI_REQ(nmi), .IRQ_REQ(irq),
        .LEVEL0_SEL(lvl0), .LEVEL1_SEL(lvl1), .WDT_PERIOD_SEL(per),
        .WDT_WINDOW_SEL(win));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // entered just after a rising edge; holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        check(k < 20, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wait_low();
        for (int k = 0; k < 300 && sys_n !== 1'b0; k++) @(posedge clock);
    endtask

    // counts edges until release, the vector fetch must come with it
    task automatic wait_rel(input int lo, input int hi);
        int k;
        k = 0;
        while (sys_n !== 1'b1 && k < 1000)
        begin
            @(posedge clock);
            k++;
        end
        check(fetch, 1'b1);
        check(k >= lo && k <= hi, 1'b1);
        @(posedge clock);
    endtask

    task automatic underflow();
        wdt_uf <= 1'b1;
        @(posedge clock);
        wdt_uf <= 1'b0;
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        // level 0 start option kept at 0 so the monitor 0 reset is live
        opt_m = 8'(rnd()) & 8'hBF;
        opt_s = 8'(rnd());
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        wait_rel(258, 262 + SEQ + 6);
        cause_m = 2;
        apb(1'b0, OFF_CAUSE, 32'h0);
        check(rd, cause_m);
        apb(1'b1, OFF_OPT, 32'hFFFF);
        apb(1'b0, OFF_OPT, 32'h0);
        check(rd, {16'h0, opt_s, opt_m});
        check({lvl0, per, win}, {opt_m[5:4], opt_s[1:0], opt_s[3:2]});
        check(clk_slow, 1'b1);
        $display("power-up test done");

        apb(1'b1, OFF_MODE1, 32'h1);
        check(clk_slow, 1'b0);
        apb(1'b1, OFF_CAUSE, 32'h1);
        cause_m |= 1;
        apb(1'b1, OFF_MODE0, 32'h8);
        cause_m |= 4;
        wait_low();
        check(sys_n, 1'b0);
        wait_rel(SEQ, SEQ + 2);
        check(clk_slow, 1'b1);
        apb(1'b0, OFF_MODE0, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFF_CAUSE, 32'h0);
        check(rd, cause_m);
        $display("software reset test done");

        underflow();
        for (int k = 0; k < 4; k++) @(posedge clock);
        check(sys_n, 1'b1);
        apb(1'b1, OFF_MODE1, 32'h4);
        underflow();
        cause_m |= 8;
        wait_low();
        check(sys_n, 1'b0);
        wait_rel(SEQ, SEQ + 2);
        apb(1'b0, OFF_CAUSE, 32'h0);
        check(rd, cause_m);
        $display("watchdog test done");

        apb(1'b1, OFF_MON, 32'h8B);
        u_rsc_partner.rail(1'b0, 1'b1);
        for (n = 0; n < 20 && nmi !== 1'b1; n++) @(posedge clock);
        check({nmi, irq}, 2'b10);
        apb(1'b0, OFF_MON, 32'h0);
        check(rd[15:0], 16'h0887);
        lvl = 4'(rnd());
        apb(1'b1, OFF_MONSEL, {24'h0, 4'h5, lvl});
        for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clock);
        check({nmi, irq}, 2'b01);
        check(lvl1, lvl);
        apb(1'b1, OFF_MON, 32'h83);
        for (n = 0; n < 20 && irq !== 1'b0; n++) @(posedge clock);
        check(irq, 1'b0);
        u_rsc_partner.rail(1'b1, 1'b1);
        // let the unfiltered level settle before the filter takes over
        repeat (4) @(posedge clock);
        apb(1'b1, OFF_MON, 32'h03B1);
        u_rsc_partner.rail(1'b0, 1'b1);
        repeat (2) @(posedge clock);
        u_rsc_partner.rail(1'b1, 1'b1);
        repeat (30) @(posedge clock);
        check({nmi, irq}, 2'b00);
        u_rsc_partner.rail(1'b0, 1'b0);
        for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clock);
        check({nmi, irq}, 2'b01);
        u_rsc_partner.rail(1'b1, 1'b1);
        for (n = 0; n < 20 && nmi !== 1'b1; n++) @(posedge clock);
        check({nmi, irq}, 2'b11);
        apb(1'b0, 8'h18, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        $display("monitor test done");

        fork
            u_rsc_partner.pin_pulse(300);
            begin
                repeat (100) @(posedge clock);
                u_rsc_partner.dip(300);
            end
        join
        check(sys_n, 1'b0);
        wait_rel(SEQ + 4, SEQ + 5);
        cause_m = 0;
        apb(1'b0, OFF_CAUSE, 32'h0);
        check(rd, cause_m);
        $display("overlap test done");

        apb(1'b1, OFF_CAUSE, 32'h1);
        check(ram_undef, 1'b0);
        ram_busy <= 1'b1;
        u_rsc_partner.pin_pulse(260);
        ram_busy <= 1'b0;
        cause_m = 3;
        wait_rel(SEQ + 1, SEQ + 5);
        check(ram_undef, 1'b1);
        apb(1'b0, OFF_CAUSE, 32'h0);
        check(rd, cause_m);
        $display("pin reset test done");

        // monitor 0 reset switched off by the option byte
        opt_m <= opt_m | 8'h40;
        apb(1'b1, OFF_MODE1, 32'h4);
        u_rsc_partner.dip(50);
        check(sys_n, 1'b1);
        // a frozen block must not see the watchdog pulse
        clk_en <= 1'b0;
        underflow();
        repeat (2) @(posedge clock);
        clk_en <= 1'b1;
        repeat (4) @(posedge clock);
        check(sys_n, 1'b1);
        apb(1'b0, OFF_CAUSE, 32'h0);
        check(rd, cause_m);
        $display("option and freeze test done");
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        num_errors++;
        end_sim();
    end
endmodule // test_reset_source_controller
